// >>> logic/timer_event_counter_defs.vh
`ifndef TIMER_EVENT_COUNTER_DEFS_VH
`define TIMER_EVENT_COUNTER_DEFS_VH
// ==========================================================
// Register map (byte addresses)
`define TEC_CONTROL_ADDR   12'h000
`define TEC_COUNT_ADDR     12'h004
`define TEC_MISC_ADDR      12'h008
`define TEC_STATUS_ADDR    12'h00C
`define TEC_MASK_ADDR      12'h010
// ==========================================================
// Control fields
`define TEC_MODE_HI        7
`define TEC_MODE_LO        6
`define TEC_CLK_SRC_BIT    5
`define TEC_RUN_BIT        4
`define TEC_EDGE_BIT       3
`define TEC_PSC_HI         2
`define TEC_PSC_LO         0
`define TEC_CONTROL_RESET  8'h08
// ==========================================================
// Misc control fields
`define TEC_REMAP_BIT      0
`define TEC_MISC_RESET     1'b0
// ==========================================================
// Mode codes
`define TEC_MODE_NONE      2'h0
`define TEC_MODE_EVENT     2'h1
`define TEC_MODE_TIMER     2'h2
`define TEC_MODE_CAPTURE   2'h3
// ==========================================================
// Counter limits
`define TEC_COUNT_MAX      8'hFF
`define TEC_PSC_RESET      7'h00
`endif

// >>> logic/input_sync2.v
`timescale 1ns/100ps
// ==========================================================
// Two-stage synchroniser
module input_sync2 (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Data
  input  wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // input_sync2

// >>> logic/prescaler_tick.v
`timescale 1ns/100ps
`include "timer_event_counter_defs.vh"
// ==========================================================
// Power-of-two prescaler, one-cycle tick output
module prescaler_tick #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       src_tick,
  input  wire       run,
  input  wire [2:0] ratio_sel,
  // Output
  output reg        tick
);
  reg  [WIDTH-1:0] div_q;
  wire [WIDTH-1:0] div_mask;

  // Terminal count is 2^ratio - 1
  assign div_mask = ~({WIDTH{1'b1}} << ratio_sel);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= `TEC_PSC_RESET;
      tick  <= 1'b0;
    end else if (!run) begin
      div_q <= `TEC_PSC_RESET;
      tick  <= 1'b0;
    end else if (src_tick) begin
      if ((div_q & div_mask) == div_mask) begin
        div_q <= `TEC_PSC_RESET;
        tick  <= 1'b1;
      end else begin
        div_q <= div_q + {{(WIDTH-1){1'b0}}, 1'b1};
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // prescaler_tick

// >>> logic/timer_event_counter_8bit.v
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "timer_event_counter_defs.vh"
module timer_event_counter_8bit #(
  parameter PSC_WIDTH = 7
) (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Clock sources and pins
  input  wire        crystal_clk_in,
  input  wire        pwm_enable,
  input  wire        event_pin_default,
  input  wire        event_pin_alt,
  // Interrupt and status
  output wire        irq,
  output reg         overflow_pulse
);
  // ==========================================================
  // Registers
  reg  [7:0] control_q;
  reg  [7:0] count_q;
  reg  [7:0] preload_q;
  reg        remap_q;
  reg        status_q;
  reg        mask_q;
  reg        pin_prev_q;
  reg        xtal_prev_q;
  reg        capture_active_q;

  wire       wr_en;
  wire       rd_en;
  wire       addr_ok;
  wire [1:0] mode;
  wire       run;
  wire       edge_sel;
  wire       pin_def_s;
  wire       pin_alt_s;
  wire       xtal_s;
  wire       pin_s;
  wire       rise;
  wire       fall;
  wire       xtal_tick;
  wire       src_tick;
  wire       psc_tick;
  wire       internal_mode;
  reg        count_step;
  reg  [7:0] count_d;
  reg  [7:0] preload_d;
  reg  [7:0] control_d;
  reg        remap_d;
  reg        mask_d;
  reg        status_d;
  reg        capture_d;
  reg        overflow_d;
  reg [31:0] prdata_d;

  wire       wr_control;
  wire       wr_count;
  wire       wr_misc;
  wire       wr_status;
  wire       wr_mask;
  wire       at_max;
  wire       start_edge;
  wire       stop_edge;
  wire       event_step;
  wire       timer_step;
  wire       capture_step;

  // ==========================================================
  // Bus decode
  assign pready  = 1'b1;
  assign addr_ok = (paddr == `TEC_CONTROL_ADDR) ||
                   (paddr == `TEC_COUNT_ADDR) ||
                   (paddr == `TEC_MISC_ADDR) ||
                   (paddr == `TEC_STATUS_ADDR) ||
                   (paddr == `TEC_MASK_ADDR);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & ~penable & ~pwrite;

  // ==========================================================
  // Write strobes per register
  assign wr_control = wr_en && (paddr == `TEC_CONTROL_ADDR);
  assign wr_count   = wr_en && (paddr == `TEC_COUNT_ADDR);
  assign wr_misc    = wr_en && (paddr == `TEC_MISC_ADDR);
  assign wr_status  = wr_en && (paddr == `TEC_STATUS_ADDR);
  assign wr_mask    = wr_en && (paddr == `TEC_MASK_ADDR);

  // ==========================================================
  // Control fields
  // mode decode
  assign mode     = control_q[`TEC_MODE_HI:`TEC_MODE_LO];
  assign run      = control_q[`TEC_RUN_BIT];
  assign edge_sel = control_q[`TEC_EDGE_BIT];

  // ==========================================================
  // Pin synchronisers
  // two-flop sync
  input_sync2 u_sync_def (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (event_pin_default),
    .sync_out (pin_def_s)
  );

  input_sync2 u_sync_alt (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (event_pin_alt),
    .sync_out (pin_alt_s)
  );

  // Crystal runs much slower than pclk, so it is sampled as a level
  input_sync2 u_sync_xtal (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (crystal_clk_in),
    .sync_out (xtal_s)
  );

  assign pin_s = remap_q ? pin_alt_s : pin_def_s;
  assign rise  = pin_s & ~pin_prev_q;
  assign fall  = ~pin_s & pin_prev_q;
  // Counting on high to low transition of the crystal
  assign xtal_tick = ~xtal_s & xtal_prev_q;

  // ==========================================================
  // Prescaler source
  // clock source
  assign src_tick = (control_q[`TEC_CLK_SRC_BIT] && !pwm_enable) ?
                    xtal_tick : 1'b1;
  assign internal_mode = (mode == `TEC_MODE_TIMER) ||
                         (mode == `TEC_MODE_CAPTURE);

  prescaler_tick #(
    .WIDTH (PSC_WIDTH)
  ) u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .src_tick  (src_tick),
    .run       (run & internal_mode),
    .ratio_sel (control_q[`TEC_PSC_HI:`TEC_PSC_LO]),
    .tick      (psc_tick)
  );

  // ==========================================================
  // Count step select
  // event edge
  assign event_step   = run & (edge_sel ? fall : rise);
  assign timer_step   = run & psc_tick;
  assign capture_step = run & capture_active_q & psc_tick;

  always @* begin
    case (mode)
      `TEC_MODE_EVENT:   count_step = event_step;
      `TEC_MODE_TIMER:   count_step = timer_step;
      `TEC_MODE_CAPTURE: count_step = capture_step;
      default:           count_step = 1'b0;
    endcase
  end

  // ==========================================================
  // Capture window and edge history
  // start and stop edges
  assign start_edge = edge_sel ? rise : fall;
  assign stop_edge  = edge_sel ? fall : rise;

  always @* begin
    capture_d = capture_active_q;
    if (mode != `TEC_MODE_CAPTURE || !run) begin
      // Leaving capture or stopping closes the window at once
      capture_d = 1'b0;
    end else if (start_edge) begin
      capture_d = 1'b1;
    end else if (stop_edge) begin
      capture_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q       <= 1'b0;
      xtal_prev_q      <= 1'b0;
      capture_active_q <= 1'b0;
    end else begin
      pin_prev_q       <= pin_s;
      xtal_prev_q      <= xtal_s;
      capture_active_q <= capture_d;
    end
  end

  // ==========================================================
  // Control registers
  always @* begin
    control_d = control_q;
    remap_d   = remap_q;
    mask_d    = mask_q;
    preload_d = preload_q;
    if (wr_control)
      control_d = pwdata[7:0];
    if (wr_misc)
      remap_d = pwdata[`TEC_REMAP_BIT];
    if (wr_mask)
      mask_d = pwdata[0];
    if (wr_count)
      preload_d = pwdata[7:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `TEC_CONTROL_RESET;
      remap_q   <= `TEC_MISC_RESET;
      mask_q    <= 1'b0;
    end else begin
      control_q <= control_d;
      remap_q   <= remap_d;
      mask_q    <= mask_d;
    end
  end

  // preload has no reset
  // Software must write it before the first reload; unknown until then
  always @(posedge pclk) begin
    preload_q <= preload_d;
  end

  // ==========================================================
  // Live counter
  assign at_max = (count_q == `TEC_COUNT_MAX);

  always @* begin
    count_d    = count_q;
    overflow_d = 1'b0;
    if (wr_count && !run) begin
      count_d = pwdata[7:0];
    end else if (count_step) begin
      if (at_max) begin
        count_d    = preload_q;
        overflow_d = 1'b1;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q        <= 8'h00;
      overflow_pulse <= 1'b0;
    end else begin
      count_q        <= count_d;
      overflow_pulse <= overflow_d;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear
  // Set wins over a clear in the same cycle, so no overflow is lost
  always @* begin
    status_d = status_q;
    if (overflow_pulse) begin
      status_d = 1'b1;
    end else if (wr_status && pwdata[0]) begin
      status_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 1'b0;
    end else begin
      status_q <= status_d;
    end
  end

  // Level output from flops only, no glitch from the bus
  assign irq = status_q & mask_q;

  // ==========================================================
  // Read data, registered in setup phase
  // Taken one cycle early so zero wait states still meet timing
  always @* begin
    case (paddr)
      `TEC_CONTROL_ADDR: prdata_d = {24'h000000, control_q};
      `TEC_COUNT_ADDR:   prdata_d = {24'h000000, count_q};
      `TEC_MISC_ADDR:    prdata_d = {31'h00000000, remap_q};
      `TEC_STATUS_ADDR:  prdata_d = {31'h00000000, status_q};
      `TEC_MASK_ADDR:    prdata_d = {31'h00000000, mask_q};
      default:           prdata_d = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= prdata_d;
    end
  end
endmodule // timer_event_counter_8bit

// >>> bench/timer_event_counter_8bit_properties.sv
`timescale 1ns/100ps
`include "timer_event_counter_defs.vh"
// ========
// Port checker
module timer_event_counter_8bit_properties (
  // APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Interrupt
  input wire        irq,
  input wire        overflow_pulse
);
  reg  [7:0] ctl_q;
  reg        mask_q;
  wire       acc = psel && penable;
  wire       wr  = acc && pwrite;
  wire       map = paddr <= `TEC_MASK_ADDR && paddr[1:0] == 2'h0;
  wire       stop = !ctl_q[`TEC_RUN_BIT] || ctl_q[7:6] == `TEC_MODE_NONE;
  // Shadow of the writable control and mask bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= `TEC_CONTROL_RESET;
      mask_q <= 1'h0;
    end else if (wr) begin
      if (paddr == `TEC_CONTROL_ADDR) ctl_q <= pwdata[7:0];
      if (paddr == `TEC_MASK_ADDR) mask_q <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ovf_armed;
    overflow_pulse && mask_q && !wr;
  endsequence
  AST_PREADY: assert property (pready) else $error("pready low");
  AST_SLVERR: assert property (acc |-> pslverr == !map)
    else $error("pslverr wrong");
  AST_UNMAP_RD: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_HI_ZERO: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_CTRL_RD: assert property (
    acc && !pwrite && paddr == `TEC_CONTROL_ADDR |-> prdata[7:0] == ctl_q)
    else $error("control readback wrong");
  AST_OVF_STOP: assert property (
    stop && $past(stop) && $past(stop, 2) |-> !overflow_pulse)
    else $error("overflow while stopped");
  AST_OVF_IRQ: assert property (s_ovf_armed |=> irq)
    else $error("irq missing after overflow");
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> $past(overflow_pulse) || $past(wr))
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr))
    else $error("irq fell without write");
  AST_IRQ_MASK: assert property (!mask_q |-> !irq)
    else $error("masked irq high");
endmodule // timer_event_counter_8bit_properties
bind timer_event_counter_8bit timer_event_counter_8bit_properties props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq),
  .overflow_pulse(overflow_pulse));

// >>> bench/event_source_model.sv
`timescale 1ns/100ps
// ========
// Event source on the timer pins
module event_source_model (
  // Pins
  output reg pin_default,
  output reg pin_alt
);
  // pins start low here; set_pin drives them afterwards
  initial begin
    pin_default = 1'h0;
    pin_alt = 1'h0;
  end
  // drives one pin level and returns at once; the caller holds it long enough to sync
  task set_pin(input logic sel, input logic val);
    begin
      if (sel) pin_alt <= val;
      else pin_default <= val;
    end
  endtask
endmodule // event_source_model

// >>> bench/timer_event_counter_8bit_tb.sv
`timescale 1ns/100ps
`include "timer_event_counter_defs.vh"
module timer_event_counter_8bit_tb;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, crystal_clk_in, pwm_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic        pready, pslverr, irq, overflow_pulse, pin_a, pin_b;
  int          fails = 0;
  int          checks = 0;
  int          n;
  logic [27:0] rows [0:4] = '{{`TEC_CONTROL_ADDR, 8'h0F, 8'h0F},
    {`TEC_MISC_ADDR, 8'h01, 8'h01}, {`TEC_MISC_ADDR, 8'h00, 8'h00},
    {12'h020, 8'hFF, 8'h00}, {`TEC_MASK_ADDR, 8'h01, 8'h01}};
  timer_event_counter_8bit #(.PSC_WIDTH(7)) timer_event_counter_8bit_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_clk_in(crystal_clk_in),
    .pwm_enable(pwm_enable), .event_pin_default(pin_a),
    .event_pin_alt(pin_b), .irq(irq), .overflow_pulse(overflow_pulse));
  event_source_model event_source_model_inst (.pin_default(pin_a),
    .pin_alt(pin_b));
  always #5 pclk = ~pclk;
  task check(input string s, input logic [31:0] seen, input logic [31:0] e);
    begin
      checks++;
      if (seen !== e) begin
        fails++;
        $display("mismatch %s expected %h seen %h", s, e, seen);
      end
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      r = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask
  task rc(input string s, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    begin
      apb(1'h0, a, 32'h0, r);
      check(s, r, e);
    end
  endtask
  task pin(input logic s, input logic l);
    begin
      event_source_model_inst.set_pin(s, l);
      repeat (6) @(posedge pclk);
    end
  endtask
  task close_out;
    begin
      if (fails == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fails++;
    close_out;
  end
  initial begin
    {presetn, psel, penable, pwrite, crystal_clk_in, pwm_enable} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rc("control", `TEC_CONTROL_ADDR, 32'h08);
    rc("misc", `TEC_MISC_ADDR, 32'h00);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][27:16], {24'h0, rows[i][15:8]});
      rc("table", rows[i][27:16], {24'h0, rows[i][7:0]});
    end
    wr(`TEC_COUNT_ADDR, 32'h55);
    rc("count", `TEC_COUNT_ADDR, 32'h55);
    wr(`TEC_CONTROL_ADDR, 32'h10);
    repeat (20) @(posedge pclk);
    rc("count", `TEC_COUNT_ADDR, 32'h55);
    wr(`TEC_CONTROL_ADDR, 32'h87);
    wr(`TEC_COUNT_ADDR, 32'hFF);
    wr(`TEC_CONTROL_ADDR, 32'h97);
    wr(`TEC_COUNT_ADDR, 32'h20);
    rc("count", `TEC_COUNT_ADDR, 32'hFF);
    for (n = 0; n < 300 && overflow_pulse !== 1'h1; n++) @(posedge pclk);
    check("overflow", {31'h0, n < 300}, 32'h1);
    repeat (90) @(posedge pclk);
    rc("count", `TEC_COUNT_ADDR, 32'h20);
    check("irq", {31'h0, irq}, 32'h1);
    repeat (60) @(posedge pclk);
    rc("count", `TEC_COUNT_ADDR, 32'h21);
    rc("status", `TEC_STATUS_ADDR, 32'h1);
    wr(`TEC_STATUS_ADDR, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    wr(`TEC_CONTROL_ADDR, 32'h80);
    wr(`TEC_COUNT_ADDR, 32'h00);
    wr(`TEC_CONTROL_ADDR, 32'hB0);
    repeat (20) @(posedge pclk);
    rc("count", `TEC_COUNT_ADDR, 32'h00);
    for (n = 0; n < 8; n++) begin
      crystal_clk_in <= 1'h1;
      repeat (3) @(posedge pclk);
      crystal_clk_in <= 1'h0;
      repeat (3) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    rc("count", `TEC_COUNT_ADDR, 32'h08);
    pwm_enable <= 1'h1;
    repeat (10) @(posedge pclk);
    apb(1'h0, `TEC_COUNT_ADDR, 32'h0, v);
    check("count", {31'h0, v != 32'h08}, 32'h1);
    wr(`TEC_CONTROL_ADDR, 32'h40);
    wr(`TEC_COUNT_ADDR, 32'h00);
    wr(`TEC_CONTROL_ADDR, 32'h50);
    pin(1'h0, 1'h1);
    pin(1'h0, 1'h0);
    pin(1'h0, 1'h1);
    rc("count", `TEC_COUNT_ADDR, 32'h02);
    wr(`TEC_CONTROL_ADDR, 32'h58);
    pin(1'h0, 1'h0);
    rc("count", `TEC_COUNT_ADDR, 32'h03);
    wr(`TEC_MISC_ADDR, 32'h1);
    pin(1'h0, 1'h1);
    pin(1'h1, 1'h1);
    pin(1'h1, 1'h0);
    rc("count", `TEC_COUNT_ADDR, 32'h04);
    // Capture: low pulse of six cycles on the remapped pin
    wr(`TEC_CONTROL_ADDR, 32'hC0);
    wr(`TEC_COUNT_ADDR, 32'h00);
    pin(1'h1, 1'h1);
    wr(`TEC_CONTROL_ADDR, 32'hD0);
    repeat (10) @(posedge pclk);
    rc("count", `TEC_COUNT_ADDR, 32'h00);
    pin(1'h1, 1'h0);
    pin(1'h1, 1'h1);
    rc("count", `TEC_COUNT_ADDR, 32'h06);
    // Reset in mid-run
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    rc("control", `TEC_CONTROL_ADDR, 32'h08);
    rc("count", `TEC_COUNT_ADDR, 32'h00);
    rc("misc", `TEC_MISC_ADDR, 32'h00);
    close_out;
  end
endmodule // timer_event_counter_8bit_tb
